/* bench/cttc_core_assertions.sv */
// Port checker for the compact timer counter core.
`timescale 1ns/100ps
`default_nettype none
module cttc_core_assertions (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire cttc_pkg::cttc_idx_type reg_sel_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire cttc_pkg::cttc_byte_type reg_wdata_i,
	input wire cttc_pkg::cttc_byte_type reg_rdata_o,
	input wire logic alt_func_first_i,
	input wire logic alt_func_second_i,
	input wire logic timer_output_pin_first_o,
	input wire logic timer_output_pin_second_o,
	input wire cttc_pkg::cttc_byte_type route_a_o,
	input wire cttc_pkg::cttc_byte_type route_b_o,
	input wire logic period_match_o,
	input wire logic counter_wrap_o
);
	import cttc_pkg::*;
	// All checks share the core clock and its reset.
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	route_reset_a: assert property ($rose(rst_n_i) |->
		route_a_o == 8'h91 && route_b_o == 8'h11) else $error("routing reset value wrong");
	route_a_wr_a: assert property (reg_wr_i && reg_sel_i == 3'h6 |=>
		route_a_o == ($past(reg_wdata_i) & 8'hf3)) else $error("route a write wrong");
	route_b_wr_a: assert property (reg_wr_i && reg_sel_i == 3'h7 |=>
		route_b_o == ($past(reg_wdata_i) & 8'h33)) else $error("route b write wrong");
	rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	high_zero_a: assert property (reg_rd_i && (reg_sel_i == 3'h3 || reg_sel_i == 3'h5) |=>
		reg_rdata_o[7:2] == 6'h00) else $error("high byte upper bits not zero");
	route_read_a: assert property (reg_rd_i && reg_sel_i == 3'h6 |=>
		reg_rdata_o == $past(route_a_o)) else $error("route a read wrong");
	pin0_other_a: assert property ((!route_a_o[0] && $stable(alt_func_first_i)) [*3] |->
		timer_output_pin_first_o == alt_func_first_i) else $error("pin0 not on other use");
	pin1_other_a: assert property ((!route_a_o[1] && $stable(alt_func_second_i)) [*3] |->
		timer_output_pin_second_o == alt_func_second_i) else $error("pin1 not on other use");
	period_gap_a: assert property (period_match_o |=> !period_match_o [*8])
		else $error("period matches too close");
	wrap_gap_a: assert property (counter_wrap_o |=> !counter_wrap_o [*8])
		else $error("wraps too close");
endmodule
bind cttc_core cttc_core_assertions cttc_core_assertions_i (.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i), .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .alt_func_first_i(alt_func_first_i),
	.alt_func_second_i(alt_func_second_i), .timer_output_pin_first_o(timer_output_pin_first_o),
	.timer_output_pin_second_o(timer_output_pin_second_o), .route_a_o(route_a_o),
	.route_b_o(route_b_o), .period_match_o(period_match_o), .counter_wrap_o(counter_wrap_o));
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the compact timer counter core.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import cttc_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	cttc_idx_type reg_sel_i = 3'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	cttc_byte_type reg_wdata_i = 8'h00;
	cttc_byte_type reg_rdata_o, route_a_o, route_b_o, hi, lo;
	logic time_base_tick_i = 1'b0;
	logic external_count_input_i = 1'b0;
	logic alt_func_first_i = 1'b0;
	logic alt_func_second_i = 1'b0;
	logic pin_invert_second_i = 1'b0;
	logic timer_output_pin_first_o, timer_output_pin_second_o;
	logic period_match_o, compare_a_match_o, counter_wrap_o;
	logic [31:0] seed = 32'hd29d_6822;
	logic [31:0] cyc = 32'h0000_0000;
	logic [31:0] r;
	logic [15:0] v;
	int num_errors = 0;
	int checks_done = 0;
	int k, c;
	int mul[8] = '{4, 1, 16, 64, 3, 0, 4, 4};
	// Free clock at 125 MHz.
	always #4 core_clk_i = ~core_clk_i;
	// Time-base ticks every third cycle; the count pin has one rising edge every fourth.
	always @(posedge core_clk_i) begin
		#1;
		cyc = cyc + 32'h0000_0001;
		time_base_tick_i = (cyc % 3 == 0);
		external_count_input_i = cyc[1];
	end
	cttc_core cttc_core_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_sel_i(reg_sel_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .time_base_tick_i(time_base_tick_i),
		.external_count_input_i(external_count_input_i), .alt_func_first_i(alt_func_first_i),
		.alt_func_second_i(alt_func_second_i), .pin_invert_second_i(pin_invert_second_i),
		.timer_output_pin_first_o(timer_output_pin_first_o),
		.timer_output_pin_second_o(timer_output_pin_second_o), .route_a_o(route_a_o),
		.route_b_o(route_b_o), .period_match_o(period_match_o),
		.compare_a_match_o(compare_a_match_o), .counter_wrap_o(counter_wrap_o));
	// Repeatable random source.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Compares with case equality so an unknown never matches.
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Register strobes last one cycle; the index and data stand with them.
	task automatic wr(input cttc_idx_type s, input cttc_byte_type d);
		@(posedge core_clk_i);
		#1;
		reg_sel_i = s;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input cttc_idx_type s, output cttc_byte_type d);
		@(posedge core_clk_i);
		#1;
		reg_sel_i = s;
		reg_rd_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
	endtask
	// Ordered pair access.
	// High byte first, so the low byte comes from the captured buffer.
	task automatic rdp(input cttc_idx_type s, output logic [15:0] q);
		rd(s, hi);
		rd(s - 3'h1, lo);
		q = {hi, lo};
	endtask
	// Cycles between two pulses; with no pulse at all the result is 3001.
	task automatic gap(input int w, input int exp, input string nm);
		int n;
		int t0;
		logic p;
		t0 = -1;
		repeat (3) @(posedge core_clk_i);
		for (n = 0; n < 3000; n++) begin
			@(posedge core_clk_i);
			#1;
			p = (w == 0) ? period_match_o : (w == 1) ? compare_a_match_o : counter_wrap_o;
			if (p === 1'b1) begin
				if (t0 >= 0) break;
				t0 = n;
			end
		end
		chk(nm, 16'(n - t0), 16'(exp));
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge core_clk_i);
		num_errors++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge core_clk_i);
		#1;
		rst_n_i = 1'b1;
		rd(3'h6, hi);
		chk("route_a reset", {8'h00, hi}, 16'h0091);
		rd(3'h7, hi);
		chk("route_b reset", {8'h00, hi}, 16'h0011);
		wr(3'h6, 8'hff);
		wr(3'h7, 8'hff);
		rd(3'h6, hi);
		chk("route_a mask", {8'h00, hi}, 16'h00f3);
		rd(3'h7, hi);
		chk("route_b mask", {8'h00, hi}, 16'h0033);
		// Compare pair: a lone low write must not reach the low byte.
		r = xs();
		wr(3'h4, r[7:0]);
		wr(3'h5, r[15:8]);
		rdp(3'h5, v);
		chk("cmp pair", v, {6'h00, r[9:0]});
		wr(3'h4, ~r[7:0]);
		rdp(3'h5, v);
		chk("cmp low held", v, {6'h00, r[9:0]});
		// The high read above refilled the buffer, so the low byte goes in again.
		wr(3'h4, ~r[7:0]);
		wr(3'h5, r[15:8]);
		rdp(3'h5, v);
		chk("cmp low copied", v, {6'h00, r[9:8], ~r[7:0]});
		// Counter: cleared by the on-bit rise, then run for a random span and paused.
		wr(3'h1, 8'hc0);
		wr(3'h0, 8'h98);
		rdp(3'h3, v);
		chk("cnt cleared", v, 16'h0000);
		k = int'(xs() % 900);
		wr(3'h0, 8'h18);
		repeat (k) @(posedge core_clk_i);
		wr(3'h0, 8'h98);
		rdp(3'h3, v);
		chk("cnt paused", v, 16'(k + 2));
		repeat (50) @(posedge core_clk_i);
		// Writes to the counter pair must leave it alone.
		wr(3'h2, 8'hff);
		wr(3'h3, 8'h03);
		rdp(3'h3, v);
		chk("cnt frozen", v, 16'(k + 2));
		wr(3'h0, 8'h00);
		wr(3'h0, 8'h98);
		rdp(3'h3, v);
		chk("cnt reclear", v, 16'h0000);
		// Pins: compare mode starts at the initial level, second pin inverted.
		wr(3'h6, 8'h93);
		wr(3'h1, 8'h08);
		pin_invert_second_i = 1'b1;
		wr(3'h0, 8'h00);
		wr(3'h0, 8'h98);
		repeat (4) @(posedge core_clk_i);
		#1;
		chk("pins cmp", {14'h0000, timer_output_pin_first_o, timer_output_pin_second_o},
			16'h0002);
		wr(3'h1, 8'hc8);
		pin_invert_second_i = 1'b0;
		repeat (4) @(posedge core_clk_i);
		#1;
		chk("pins timer", {14'h0000, timer_output_pin_first_o, timer_output_pin_second_o},
			16'h0000);
		r = xs();
		alt_func_first_i = r[0];
		alt_func_second_i = r[1];
		wr(3'h6, 8'h90);
		repeat (4) @(posedge core_clk_i);
		#1;
		chk("pins other", {14'h0000, timer_output_pin_first_o, timer_output_pin_second_o},
			{14'h0000, r[0], r[1]});
		// Every clock source against a small random compare-A clear point.
		c = 2 + int'(xs() % 8);
		wr(3'h1, 8'h01);
		wr(3'h4, 8'(c));
		wr(3'h5, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(3'h0, {1'b0, 3'(i), 4'h8});
			gap(1, (mul[i] == 0) ? 3001 : mul[i] * c, "source gap");
		end
		// A zero compare value only matches at rollover, so run on the core clock.
		wr(3'h4, 8'h00);
		wr(3'h5, 8'h00);
		wr(3'h0, 8'h18);
		gap(1, 1024, "cmp zero gap");
		// Compare mode: a start restores the initial level, a match sets the action level.
		wr(3'h6, 8'h93);
		wr(3'h4, 8'h03);
		wr(3'h5, 8'h00);
		for (int a = 0; a < 2; a++) begin
			wr(3'h1, (a == 0) ? 8'h21 : 8'h19);
			wr(3'h0, 8'h00);
			wr(3'h0, 8'h98);
			repeat (4) @(posedge core_clk_i);
			#1;
			chk("pins start", {14'h0000, timer_output_pin_first_o, timer_output_pin_second_o},
				{14'h0000, a[0], a[0]});
			wr(3'h0, 8'h18);
			repeat (8) @(posedge core_clk_i);
			#1;
			chk("pins match", {14'h0000, timer_output_pin_first_o, timer_output_pin_second_o},
				{14'h0000, !a[0], !a[0]});
		end
		// Period field sweep with period-match clearing.
		wr(3'h1, 8'hc0);
		for (int f = 0; f < 8; f++) begin
			wr(3'h0, {4'h1, 1'b1, 3'(f)});
			gap(0, (f == 0) ? 1024 : 128 * f, "period gap");
		end
		// A zero period field lets the counter run to its top value.
		wr(3'h0, 8'h18);
		gap(2, 1024, "wrap gap");
		// PWM: over one 128-clock period the pin is high for as many clocks as the duty.
		r = xs();
		wr(3'h4, {1'b0, r[6:0]});
		wr(3'h5, 8'h00);
		wr(3'h1, 8'ha8);
		wr(3'h0, 8'h00);
		wr(3'h0, 8'h19);
		repeat (4) @(posedge core_clk_i);
		k = 0;
		repeat (128) begin
			@(posedge core_clk_i);
			#1;
			if (timer_output_pin_first_o === 1'b1) k++;
		end
		chk("pwm duty", 16'(k), {9'h000, r[6:0]});
		final_report();
	end
endmodule
`default_nettype wire

/* logic/cttc_consts.svh */
// Constants for the compact timer counter core: offsets, fields, reset values, counts.
// Contract
// - Ten-bit up-counter advanced by a selectable internal or external pin clock.
// - Period comparator matches its three bits against counter bits nine to seven.
// - Compare-A matches its full ten bits against the whole counter.
// - Software cannot load the counter; an on-bit rise is its only software clear.
// - Overflow or selected compare match clears the counter and raises a request.
// - Low bytes of counter and compare-A pass through one eight-bit buffer.
// - Compare low byte write lands in the buffer only.
// - Compare high byte write stores high bits and copies buffer to low byte.
// - High byte read returns high bits and captures the low byte into buffer.
// - Low byte read returns the buffer, not the live low byte.
// - Counter is a read-only pair; compare-A is a read/write pair.
// - Counter high byte holds bits nine and eight in bits one and zero.
// - Unimplemented bits of routing and counter registers read as zero.
// - A routing bit of one gives its pin to the timer, zero to another use.
// - Modes are compare match output, timer/event counter and PWM output.
// - Timer drives one or two pins, second pin same or inverted.
// - Clock select offers sys/4, sys, high/16, high/64, time base, pin edges; 101 stops.
// - Period field counts in 128-clock steps; zero means a 1024-clock period.
// - Clear select zero clears on period match, one on compare-A match.
// - Pause freezes the counter value, clearing pause resumes from it.
`ifndef CTTC_CONSTS_SVH
`define CTTC_CONSTS_SVH
`define CTTC_IDX_CTRL0 3'h0
`define CTTC_IDX_CTRL1 3'h1
`define CTTC_IDX_CNT_LO 3'h2
`define CTTC_IDX_CNT_HI 3'h3
`define CTTC_IDX_CMP_LO 3'h4
`define CTTC_IDX_CMP_HI 3'h5
`define CTTC_IDX_ROUTE_A 3'h6
`define CTTC_IDX_ROUTE_B 3'h7
`define CTTC_C0_PAUSE 7
`define CTTC_C0_ON 3
`define CTTC_C1_OC 3
`define CTTC_C1_POL 2
`define CTTC_C1_DPX 1
`define CTTC_C1_CCLR 0
`define CTTC_CTRL_RST 8'h00
`define CTTC_ROUTE_A_RST 8'h91
`define CTTC_ROUTE_B_RST 8'h11
`define CTTC_ROUTE_A_MASK 8'hf3
`define CTTC_ROUTE_B_MASK 8'h33
`define CTTC_CK_SYS_DIV4 3'h0
`define CTTC_CK_SYS 3'h1
`define CTTC_CK_HI_DIV16 3'h2
`define CTTC_CK_HI_DIV64 3'h3
`define CTTC_CK_TBC 3'h4
`define CTTC_CK_OFF 3'h5
`define CTTC_CK_PIN_RISE 3'h6
`define CTTC_CK_PIN_FALL 3'h7
`define CTTC_MODE_COMPARE 2'h0
`define CTTC_MODE_PWM 2'h2
`define CTTC_MODE_TIMER 2'h3
`define CTTC_PERIOD_STEP_BITS 7
`endif

/* logic/cttc_core.sv */
// Compact timer counter core with byte-wide register port and routed output pins.
`timescale 1ns/100ps
`default_nettype none
`include "cttc_consts.svh"
module cttc_core #(
	parameter int CNT_W = 10,
	parameter int PRESC_W = 6
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire cttc_pkg::cttc_idx_type reg_sel_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire cttc_pkg::cttc_byte_type reg_wdata_i,
	output cttc_pkg::cttc_byte_type reg_rdata_o,
	input wire logic time_base_tick_i,
	input wire logic external_count_input_i,
	input wire logic alt_func_first_i,
	input wire logic alt_func_second_i,
	input wire logic pin_invert_second_i,
	output logic timer_output_pin_first_o,
	output logic timer_output_pin_second_o,
	output cttc_pkg::cttc_byte_type route_a_o,
	output cttc_pkg::cttc_byte_type route_b_o,
	output logic period_match_o,
	output logic compare_a_match_o,
	output logic counter_wrap_o
);
	import cttc_pkg::*;

	// Register select decode, shared by the write strobes and the high-byte read strobes.
	function automatic logic reg_hit(input cttc_idx_type sel, input cttc_idx_type idx);
		reg_hit = (sel == idx);
	endfunction

	cttc_byte_type ctrl0_reg;
	cttc_byte_type ctrl1_reg;
	cttc_byte_type route_a_reg;
	cttc_byte_type route_b_reg;
	cttc_count_type cnt_reg;
	cttc_count_type cnt_next;
	logic [1:0] cmp_hi_reg;
	cttc_byte_type cmp_lo_reg;
	cttc_byte_type hold_buf_reg;
	cttc_byte_type rdata_reg;
	logic [PRESC_W-1:0] presc_reg;
	logic ext_prev_reg;
	logic tm_level_reg;
	logic pin_first_reg;
	logic pin_second_reg;
	logic period_match_reg;
	logic compare_a_match_reg;
	logic wrap_reg;
	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wr_cmp_lo;
	logic wr_cmp_hi;
	logic wr_route_a;
	logic wr_route_b;
	logic rd_cnt_hi;
	logic rd_cmp_hi;
	logic on_bit;
	logic pause_bit;
	logic on_rise;
	logic [2:0] clk_sel;
	logic [2:0] period_field;
	cttc_mode_type mode;
	cttc_action_type action;
	logic tick;
	logic count_en;
	logic [CNT_W:0] inc;
	cttc_count_type cmp_a;
	logic p_hit;
	logic a_hit;
	logic wrap_hit;
	logic clear_hit;
	logic pwm_active;
	logic out_pol;

	// Counter pair read-only.
	// Access strobes; a write and a read in one cycle are both acted on.
	assign wr_ctrl0 = reg_wr_i && reg_hit(reg_sel_i, `CTTC_IDX_CTRL0);
	assign wr_ctrl1 = reg_wr_i && reg_hit(reg_sel_i, `CTTC_IDX_CTRL1);
	assign wr_cmp_lo = reg_wr_i && reg_hit(reg_sel_i, `CTTC_IDX_CMP_LO);
	assign wr_cmp_hi = reg_wr_i && reg_hit(reg_sel_i, `CTTC_IDX_CMP_HI);
	assign wr_route_a = reg_wr_i && reg_hit(reg_sel_i, `CTTC_IDX_ROUTE_A);
	assign wr_route_b = reg_wr_i && reg_hit(reg_sel_i, `CTTC_IDX_ROUTE_B);
	assign rd_cnt_hi = reg_rd_i && reg_hit(reg_sel_i, `CTTC_IDX_CNT_HI);
	assign rd_cmp_hi = reg_rd_i && reg_hit(reg_sel_i, `CTTC_IDX_CMP_HI);

	// Control field views.
	assign on_bit = ctrl0_reg[`CTTC_C0_ON];
	assign pause_bit = ctrl0_reg[`CTTC_C0_PAUSE];
	assign clk_sel = ctrl0_reg[6:4];
	assign period_field = ctrl0_reg[2:0];
	assign mode = ctrl1_reg[7:6];
	assign action = cttc_action_type'(ctrl1_reg[5:4]);
	assign out_pol = ctrl1_reg[`CTTC_C1_POL];
	assign cmp_a = {cmp_hi_reg, cmp_lo_reg};

	assign on_rise = wr_ctrl0 && reg_wdata_i[`CTTC_C0_ON] && !on_bit;

	// Control registers reset to all zeros, counter off.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl0_reg <= `CTTC_CTRL_RST;
		end else if (wr_ctrl0) begin
			ctrl0_reg <= reg_wdata_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl1_reg <= `CTTC_CTRL_RST;
		end else if (wr_ctrl1) begin
			ctrl1_reg <= reg_wdata_i;
		end
	end

	// Pin routing storage.
	// Bits for the other timers are kept here so their pin muxes can use them.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			route_a_reg <= `CTTC_ROUTE_A_RST;
			route_b_reg <= `CTTC_ROUTE_B_RST;
		end else begin
			if (wr_route_a) begin
				route_a_reg <= reg_wdata_i & `CTTC_ROUTE_A_MASK;
			end
			if (wr_route_b) begin
				route_b_reg <= reg_wdata_i & `CTTC_ROUTE_B_MASK;
			end
		end
	end

	// Free-running prescaler; the high clock is taken to be the core clock.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	// Previous level of the count pin, for edge detection.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= external_count_input_i;
		end
	end

	// Clock source select.
	// Every source is a one-cycle enable, so the counter stays on the core clock.
	always_comb begin
		case (clk_sel)
			`CTTC_CK_SYS_DIV4: tick = &presc_reg[1:0];
			`CTTC_CK_SYS: tick = 1'b1;
			`CTTC_CK_HI_DIV16: tick = &presc_reg[3:0];
			`CTTC_CK_HI_DIV64: tick = &presc_reg[5:0];
			`CTTC_CK_TBC: tick = time_base_tick_i;
			`CTTC_CK_OFF: tick = 1'b0;
			`CTTC_CK_PIN_RISE: tick = external_count_input_i && !ext_prev_reg;
			`CTTC_CK_PIN_FALL: tick = !external_count_input_i && ext_prev_reg;
			default: tick = 1'b0;
		endcase
	end

	assign count_en = on_bit && !pause_bit && tick;

	assign inc = {1'b0, cnt_reg} + 1'b1;

	// Period match on top bits.
	// A zero field matches only when the count rolls over, giving 1024 clocks.
	// Period steps of 128.
	assign p_hit = (inc[CNT_W-1:`CTTC_PERIOD_STEP_BITS] == period_field) &&
		(inc[`CTTC_PERIOD_STEP_BITS-1:0] == '0);

	assign a_hit = (inc[CNT_W-1:0] == cmp_a);

	assign wrap_hit = inc[CNT_W];

	assign clear_hit = ctrl1_reg[`CTTC_C1_CCLR] ? a_hit : p_hit;

	always_comb begin
		if (clear_hit || wrap_hit) begin
			cnt_next = '0;
		end else begin
			cnt_next = inc[CNT_W-1:0];
		end
	end

	// Counter update, software start clear only.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
		end else if (on_rise) begin
			cnt_reg <= '0;
		end else if (count_en) begin
			cnt_reg <= cnt_next;
		end
	end

	// Request pulses.
	// One pulse per match, raised on the same edge as the count step that reaches the value.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			period_match_reg <= 1'b0;
			compare_a_match_reg <= 1'b0;
			wrap_reg <= 1'b0;
		end else begin
			period_match_reg <= count_en && p_hit;
			compare_a_match_reg <= count_en && a_hit;
			wrap_reg <= count_en && wrap_hit;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmp_hi_reg <= '0;
			cmp_lo_reg <= '0;
		end else if (wr_cmp_hi) begin
			cmp_hi_reg <= reg_wdata_i[1:0];
			cmp_lo_reg <= hold_buf_reg;
		end
	end

	// Shared low-byte buffer.
	// One buffer serves both pairs, so interleaved sequences corrupt each other.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_buf_reg <= '0;
		end else if (wr_cmp_lo) begin
			hold_buf_reg <= reg_wdata_i;
		end else if (rd_cnt_hi) begin
			hold_buf_reg <= cnt_reg[7:0];
		end else if (rd_cmp_hi) begin
			hold_buf_reg <= cmp_lo_reg;
		end
	end

	// Read data path.
	// Read data is registered and appears the cycle after the read strobe.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_reg <= '0;
		end else if (reg_rd_i) begin
			case (reg_sel_i)
				`CTTC_IDX_CTRL0: rdata_reg <= ctrl0_reg;
				`CTTC_IDX_CTRL1: rdata_reg <= ctrl1_reg;
				`CTTC_IDX_CNT_LO: rdata_reg <= hold_buf_reg;
				`CTTC_IDX_CNT_HI: rdata_reg <= {6'h00, cnt_reg[9:8]};
				`CTTC_IDX_CMP_LO: rdata_reg <= hold_buf_reg;
				`CTTC_IDX_CMP_HI: rdata_reg <= {6'h00, cmp_hi_reg};
				`CTTC_IDX_ROUTE_A: rdata_reg <= route_a_reg & `CTTC_ROUTE_A_MASK;
				`CTTC_IDX_ROUTE_B: rdata_reg <= route_b_reg & `CTTC_ROUTE_B_MASK;
				default: rdata_reg <= '0;
			endcase
		end
	end

	// PWM duty test; the swap bit picks which comparator sets the duty, clear select sets the period.
	always_comb begin
		if (ctrl1_reg[`CTTC_C1_DPX]) begin
			pwm_active = cnt_reg < {period_field, 7'h00};
		end else begin
			pwm_active = cnt_reg < cmp_a;
		end
	end

	// Output waveform per mode.
	// The level is held before polarity so a start restores the initial level.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tm_level_reg <= 1'b0;
		end else begin
			case (mode)
				`CTTC_MODE_COMPARE: begin
					if (on_rise) begin
						tm_level_reg <= ctrl1_reg[`CTTC_C1_OC];
					end else if (count_en && a_hit) begin
						case (action)
							CTTC_ACT_LOW: tm_level_reg <= 1'b0;
							CTTC_ACT_HIGH: tm_level_reg <= 1'b1;
							CTTC_ACT_TOGGLE: tm_level_reg <= !tm_level_reg;
							default: tm_level_reg <= tm_level_reg;
						endcase
					end
				end
				`CTTC_MODE_PWM: begin
					case (ctrl1_reg[5:4])
						2'h0: tm_level_reg <= !ctrl1_reg[`CTTC_C1_OC];
						2'h1: tm_level_reg <= ctrl1_reg[`CTTC_C1_OC];
						2'h2: tm_level_reg <= on_bit && pwm_active ?
							ctrl1_reg[`CTTC_C1_OC] : !ctrl1_reg[`CTTC_C1_OC];
						default: tm_level_reg <= tm_level_reg;
					endcase
				end
				`CTTC_MODE_TIMER: tm_level_reg <= 1'b0;
				default: tm_level_reg <= tm_level_reg;
			endcase
		end
	end

	// Second pin same or inverted.
	// Polarity has no effect in timer mode, where routing should be off anyway.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_first_reg <= 1'b0;
			pin_second_reg <= 1'b0;
		end else begin
			if (route_a_reg[0]) begin
				pin_first_reg <= tm_level_reg ^ (out_pol && mode != `CTTC_MODE_TIMER);
			end else begin
				pin_first_reg <= alt_func_first_i;
			end
			if (route_a_reg[1]) begin
				pin_second_reg <= tm_level_reg ^ (out_pol && mode != `CTTC_MODE_TIMER) ^
					pin_invert_second_i;
			end else begin
				pin_second_reg <= alt_func_second_i;
			end
		end
	end

	// Port drive.
	assign reg_rdata_o = rdata_reg;
	assign timer_output_pin_first_o = pin_first_reg;
	assign timer_output_pin_second_o = pin_second_reg;
	assign route_a_o = route_a_reg;
	assign route_b_o = route_b_reg;
	assign period_match_o = period_match_reg;
	assign compare_a_match_o = compare_a_match_reg;
	assign counter_wrap_o = wrap_reg;

endmodule
`default_nettype wire

/* logic/cttc_pkg.sv */
// Types shared by the compact timer counter core.
`default_nettype none
package cttc_pkg;
	typedef logic [7:0] cttc_byte_type;
	typedef logic [9:0] cttc_count_type;
	typedef logic [2:0] cttc_idx_type;
	typedef logic [1:0] cttc_mode_type;
	typedef enum logic [1:0] {
		CTTC_ACT_HOLD,
		CTTC_ACT_LOW,
		CTTC_ACT_HIGH,
		CTTC_ACT_TOGGLE
	} cttc_action_type;
endpackage
`default_nettype wire
